/* rtl/fdc_seek_pkg.sv */
// constants and types for the floppy head seek control block
package fdc_seek_pkg;

  // clock and time base
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int UNIT_CYC = MS_NS / CLK_NS; // one step-time unit at 500 kbps
  localparam int STEP_W_NS = 4000;
  localparam logic [9:0] STEP_W_CYC = 10'((STEP_W_NS + CLK_NS - 1) / CLK_NS);

  // register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_SPECIFY = 8'h02;
  localparam logic [7:0] REG_HLT = 8'h03;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_RATE = 8'h05;
  localparam logic [7:0] REG_RESULT0 = 8'h06;
  localparam logic [7:0] REG_RESULT1 = 8'h07;

  // command opcodes in bits 7:4 of a command write, drive in bits 1:0
  localparam logic [3:0] OP_RECAL = 4'h1;
  localparam logic [3:0] OP_SEEK = 4'h2;
  localparam logic [3:0] OP_SENSE_INT = 4'h3;
  localparam logic [3:0] OP_SENSE_DRV = 4'h4;
  localparam logic [3:0] OP_XFER_START = 4'h5;
  localparam logic [3:0] OP_XFER_END = 4'h6;
  localparam logic [3:0] OP_WAKE = 4'h7;

  // field positions
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SPEC_SRT_MSB = 7;
  localparam int SPEC_SRT_LSB = 4;
  localparam int SPEC_HUT_MSB = 3;
  localparam int SPEC_HUT_LSB = 0;
  localparam int HLT_MSB = 7;
  localparam int HLT_LSB = 1;

  // reset values
  localparam logic [7:0] SPEC_RST = 8'h00;
  localparam logic [6:0] HLT_RST = 7'h00;
  localparam logic [1:0] RATE_RST = 2'h0;

  // timing figures in step-time units at 500 kbps, and the recalibrate step limit
  localparam logic [8:0] SRT_BASE = 9'h010;
  localparam logic [8:0] HUT_UNIT = 9'h010;
  localparam logic [8:0] HUT_ZERO = 9'h100;
  localparam logic [8:0] HLT_UNIT = 9'h002;
  localparam logic [8:0] HLT_ZERO = 9'h100;
  localparam logic [6:0] RECAL_MAX_STEPS = 7'd79;

  // data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;

  // interrupt cause codes
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID = 2'h2;
  localparam logic [1:0] IC_POLL = 2'h3;

  typedef struct packed {
    logic [1:0] interrupt_cause_code;
    logic seek_end_flag;
    logic equipment_check_flag;
    logic not_ready;
    logic head;
    logic [1:0] drive;
  } status_reg_zero_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [1:0] {DRV_IDLE, DRV_RECAL, DRV_SEEK} drv_state_e;
  typedef enum logic [1:0] {HD_UNLOADED, HD_LOADING, HD_XFER, HD_UNLOADING} head_state_e;

endpackage

/* rtl/floppy_head_seek_control.sv */
// head positioning, interrupt sense and head timing for a four drive floppy controller
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - recalibrate zeroes cylinder then watches track zero
// - recalibrate steps outward while track zero low
// - track zero high ends recalibrate, seek end
// - 79 steps without track zero: equipment check
// - recalibrate busy only in command phase
// - seek direction from cylinder compare, then step
// - steps spaced by step time, stop on match
// - seek busy only in command phase
// - head bit of status zero reads zero
// - leaving low power clears cylinders and status
// - interrupt on transfer result phase entry
// - interrupt when seek or recalibrate ends
// - sense interrupt clears and reports cause
// - seek end 0 polling, code 01 abnormal
// - drive stays busy until sense interrupt
// - sense drive status returns status three directly
// - unload and load times around transfers
// - first step gap may be shorter
// - unload code times 16, step 16 minus code
// - load 2 per count, all scale with rate
// - only dma mode, no-dma bit forced zero
// - equipment check sits in status zero bit 4
module floppy_head_seek_control #(
  parameter int UNIT_CYCLES = fdc_seek_pkg::UNIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire fdc_seek_pkg::reg_req_s i_req,
  output logic [7:0] o_rdata,
  input wire logic [3:0] i_track_zero_n,
  output logic [3:0] o_step,
  output logic [3:0] o_dir,
  output logic o_head_load,
  output logic o_xfer_go,
  output logic o_int
);
  import fdc_seek_pkg::*;

  // scaled tick period for the selected data rate
  function automatic logic [23:0] tick_period(input logic [1:0] rate);
    logic [23:0] base;
    base = 24'(UNIT_CYCLES);
    case (rate)
      RATE_300K: tick_period = 24'((UNIT_CYCLES * 5) / 3);
      RATE_250K: tick_period = 24'(base << 1);
      RATE_1M: tick_period = 24'(base >> 1);
      default: tick_period = base;
    endcase
  endfunction

  // converts a zero-means-maximum code to units
  function automatic logic [8:0] code_time(input logic [6:0] code, input logic [8:0] unit, input logic [8:0] zero);
    logic [15:0] prod;
    prod = 16'(code) * 16'(unit);
    code_time = (code == 7'h00) ? zero : prod[8:0];
  endfunction

  logic [7:0] spec_q;
  logic [6:0] hlt_q;
  logic [7:0] target_in_q;
  logic [1:0] rate_q;
  logic [3:0] trk_m_q;
  logic [3:0] trk_s_q;
  logic [23:0] tick_cnt_q;
  logic tick_q;
  drv_state_e state_q [4];
  logic [7:0] pcn_q [4];
  logic [7:0] tgt_q [4];
  logic [6:0] steps_q [4];
  logic [8:0] ivl_q [4];
  logic [9:0] pw_q [4];
  status_reg_zero_s st0_q [4];
  logic [3:0] pending_q;
  logic [3:0] step_q;
  logic [3:0] dir_q;
  head_state_e head_q;
  logic [8:0] hd_tmr_q;
  logic [1:0] hd_drive_q;
  logic xfer_int_q;
  logic poll_q;
  logic cmd_busy_q;
  logic [7:0] result0_q;
  logic [7:0] result1_q;
  logic [7:0] rdata_q;
  logic int_q;
  logic head_load_q;
  logic xfer_go_q;

  logic cmd_wr;
  logic [3:0] op;
  logic [1:0] cmd_drv;
  logic cmd_sense;
  logic any_pending;
  logic [1:0] sel_drv;
  logic [8:0] srt_units;
  logic [3:0] drv_busy;

  // command decode from a write to the command register
  assign cmd_wr = i_req.wr && (i_req.addr == REG_CMD);
  assign op = i_req.wdata[OP_MSB:OP_LSB];
  assign cmd_drv = i_req.wdata[1:0];
  assign cmd_sense = cmd_wr && (op == OP_SENSE_INT);
  assign any_pending = |pending_q;
  assign srt_units = SRT_BASE - 9'(spec_q[SPEC_SRT_MSB:SPEC_SRT_LSB]);

  // lowest numbered drive with an interrupt waiting
  always_comb
  begin
    sel_drv = 2'h0;
    for (int d = 3; d >= 0; d--)
    begin
      if (pending_q[d])
      begin
        sel_drv = 2'(d);
      end
    end
  end

  // a drive reads busy while positioning or until sensed
  always_comb
  begin
    for (int d = 0; d < 4; d++)
    begin
      drv_busy[d] = (state_q[d] != DRV_IDLE) || pending_q[d];
    end
  end

  // software written configuration
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      spec_q <= SPEC_RST;
      hlt_q <= HLT_RST;
      target_in_q <= 8'h00;
      rate_q <= RATE_RST;
    end
    else if (i_req.wr)
    begin
      if (i_req.addr == REG_SPECIFY)
      begin
        spec_q <= i_req.wdata;
      end
      else if (i_req.addr == REG_HLT)
      begin
        hlt_q <= i_req.wdata[HLT_MSB:HLT_LSB]; // no-dma bit is dropped
      end
      else if (i_req.addr == REG_TARGET)
      begin
        target_in_q <= i_req.wdata;
      end
      else if (i_req.addr == REG_RATE)
      begin
        rate_q <= i_req.wdata[1:0];
      end
    end
  end

  // two-stage synchroniser for track zero pins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      trk_m_q <= 4'hf;
      trk_s_q <= 4'hf;
    end
    else
    begin
      trk_m_q <= i_track_zero_n;
      trk_s_q <= trk_m_q;
    end
  end

  // time unit tick, its period scales with data rate
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q >= tick_period(rate_q) - 24'h000001)
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // per drive positioning engines, run in parallel
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int d = 0; d < 4; d++)
      begin
        state_q[d] <= DRV_IDLE;
        pcn_q[d] <= 8'h00;
        tgt_q[d] <= 8'h00;
        steps_q[d] <= 7'h00;
        ivl_q[d] <= 9'h000;
        pw_q[d] <= 10'h000;
        st0_q[d] <= '0;
      end
      pending_q <= 4'h0;
      step_q <= 4'h0;
      dir_q <= 4'h0;
    end
    else
    begin
      for (int d = 0; d < 4; d++)
      begin
        // pulse width and interval countdown
        if (pw_q[d] != 10'h000)
        begin
          pw_q[d] <= pw_q[d] - 10'h001;
          if (pw_q[d] == 10'h001)
          begin
            step_q[d] <= 1'b0;
          end
        end
        if (tick_q && ivl_q[d] != 9'h000)
        begin
          ivl_q[d] <= ivl_q[d] - 9'h001;
        end
        // clears first so a same-cycle completion wins
        if (cmd_sense && any_pending && sel_drv == 2'(d))
        begin
          pending_q[d] <= 1'b0;
        end
        if (cmd_wr && op == OP_WAKE)
        begin
          pcn_q[d] <= 8'h00;
          st0_q[d] <= '0;
          pending_q[d] <= 1'b0;
        end
        if (cmd_wr && cmd_drv == 2'(d) && op == OP_RECAL)
        begin
          state_q[d] <= DRV_RECAL;
          pcn_q[d] <= 8'h00;
          steps_q[d] <= 7'h00;
          ivl_q[d] <= 9'h000; // first gap short
          dir_q[d] <= 1'b0;
        end
        else if (cmd_wr && cmd_drv == 2'(d) && op == OP_SEEK)
        begin
          state_q[d] <= DRV_SEEK;
          tgt_q[d] <= target_in_q;
          ivl_q[d] <= 9'h000;
        end
        else if (ivl_q[d] == 9'h000 && pw_q[d] == 10'h000)
        begin
          case (state_q[d])
            DRV_RECAL:
            begin
              if (trk_s_q[d])
              begin
                state_q[d] <= DRV_IDLE;
                pending_q[d] <= 1'b1;
                st0_q[d] <= {IC_NORMAL, 1'b1, 1'b0, 1'b0, 1'b0, 2'(d)};
              end
              else if (steps_q[d] == RECAL_MAX_STEPS)
              begin
                state_q[d] <= DRV_IDLE;
                pending_q[d] <= 1'b1;
                st0_q[d] <= {IC_ABNORMAL, 1'b1, 1'b1, 1'b0, 1'b0, 2'(d)};
              end
              else
              begin
                dir_q[d] <= 1'b0;
                step_q[d] <= 1'b1;
                pw_q[d] <= STEP_W_CYC;
                steps_q[d] <= steps_q[d] + 7'h01;
                ivl_q[d] <= srt_units;
              end
            end
            DRV_SEEK:
            begin
              if (pcn_q[d] == tgt_q[d])
              begin
                state_q[d] <= DRV_IDLE;
                pending_q[d] <= 1'b1;
                st0_q[d] <= {IC_NORMAL, 1'b1, 1'b0, 1'b0, 1'b0, 2'(d)};
              end
              else
              begin
                dir_q[d] <= (pcn_q[d] < tgt_q[d]);
                step_q[d] <= 1'b1;
                pw_q[d] <= STEP_W_CYC;
                ivl_q[d] <= srt_units;
                if (pcn_q[d] < tgt_q[d])
                begin
                  pcn_q[d] <= pcn_q[d] + 8'h01;
                end
                else
                begin
                  pcn_q[d] <= pcn_q[d] - 8'h01;
                end
              end
            end
            default:
            begin
              state_q[d] <= DRV_IDLE;
            end
          endcase
        end
      end
    end
  end

  // head load, transfer and unload timing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      head_q <= HD_UNLOADED;
      hd_tmr_q <= 9'h000;
      hd_drive_q <= 2'h0;
    end
    else
    begin
      if (tick_q && hd_tmr_q != 9'h000)
      begin
        hd_tmr_q <= hd_tmr_q - 9'h001;
      end
      case (head_q)
        HD_UNLOADED:
        begin
          if (cmd_wr && op == OP_XFER_START)
          begin
            head_q <= HD_LOADING;
            hd_drive_q <= cmd_drv;
            hd_tmr_q <= code_time(hlt_q, HLT_UNIT, HLT_ZERO);
          end
        end
        HD_LOADING:
        begin
          if (hd_tmr_q == 9'h000)
          begin
            head_q <= HD_XFER;
          end
        end
        HD_XFER:
        begin
          if (cmd_wr && op == OP_XFER_END)
          begin
            head_q <= HD_UNLOADING;
            hd_tmr_q <= code_time(7'(spec_q[SPEC_HUT_MSB:SPEC_HUT_LSB]), HUT_UNIT, HUT_ZERO);
          end
        end
        default:
        begin
          if (cmd_wr && op == OP_XFER_START)
          begin
            head_q <= HD_XFER; // head still loaded, no load delay
            hd_drive_q <= cmd_drv;
          end
          else if (hd_tmr_q == 9'h000)
          begin
            head_q <= HD_UNLOADED;
          end
        end
      endcase
    end
  end

  // transfer and polling interrupt sources
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      xfer_int_q <= 1'b0;
      poll_q <= 1'b1;
    end
    else
    begin
      if (cmd_sense && !any_pending)
      begin
        xfer_int_q <= 1'b0;
        if (!xfer_int_q)
        begin
          poll_q <= 1'b0;
        end
      end
      if (cmd_wr && op == OP_XFER_END && head_q == HD_XFER)
      begin
        xfer_int_q <= 1'b1;
      end
      if (cmd_wr && op == OP_WAKE)
      begin
        poll_q <= 1'b0;
      end
    end
  end

  // result bytes of sense commands
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      result0_q <= 8'h00;
      result1_q <= 8'h00;
    end
    else if (cmd_sense)
    begin
      if (any_pending)
      begin
        result0_q <= st0_q[sel_drv];
        result1_q <= pcn_q[sel_drv];
      end
      else if (xfer_int_q)
      begin
        result0_q <= {IC_NORMAL, 4'h0, hd_drive_q};
        result1_q <= pcn_q[hd_drive_q];
      end
      else if (poll_q)
      begin
        result0_q <= {IC_POLL, 6'h00}; // seek end clear
        result1_q <= 8'h00;
      end
      else
      begin
        result0_q <= {IC_INVALID, 6'h00};
        result1_q <= 8'h00;
      end
    end
    else if (cmd_wr && op == OP_SENSE_DRV)
    begin
      result0_q <= {3'h1, trk_s_q[cmd_drv], 2'h0, cmd_drv};
      result1_q <= pcn_q[cmd_drv];
    end
    else if (cmd_wr && op == OP_WAKE)
    begin
      result0_q <= 8'h00;
      result1_q <= 8'h00;
    end
  end

  // busy only for the command cycle itself
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmd_busy_q <= 1'b0;
    end
    else
    begin
      cmd_busy_q <= cmd_wr;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_req.rd)
    begin
      if (i_req.addr == REG_STATUS)
      begin
        rdata_q <= {int_q, head_load_q, xfer_go_q, cmd_busy_q, drv_busy};
      end
      else if (i_req.addr == REG_SPECIFY)
      begin
        rdata_q <= spec_q;
      end
      else if (i_req.addr == REG_HLT)
      begin
        rdata_q <= {hlt_q, 1'b0}; // dma mode always
      end
      else if (i_req.addr == REG_TARGET)
      begin
        rdata_q <= target_in_q;
      end
      else if (i_req.addr == REG_RATE)
      begin
        rdata_q <= {6'h00, rate_q};
      end
      else if (i_req.addr == REG_RESULT0)
      begin
        rdata_q <= result0_q;
      end
      else if (i_req.addr == REG_RESULT1)
      begin
        rdata_q <= result1_q;
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // registered pin and interrupt outputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      int_q <= 1'b0;
      head_load_q <= 1'b0;
      xfer_go_q <= 1'b0;
    end
    else
    begin
      int_q <= any_pending || xfer_int_q || poll_q;
      head_load_q <= (head_q != HD_UNLOADED);
      xfer_go_q <= (head_q == HD_XFER);
    end
  end

  assign o_rdata = rdata_q;
  assign o_step = step_q;
  assign o_dir = dir_q;
  assign o_head_load = head_load_q;
  assign o_xfer_go = xfer_go_q;
  assign o_int = int_q;

endmodule // floppy_head_seek_control

`default_nettype wire

/* dv/floppy_drive_model.sv */
// behavioural four-drive floppy mechanism facing the seek block
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_model #(
  parameter logic [31:0] START = 32'h0
) (
  input wire logic i_clk,
  input wire logic [3:0] i_step,
  input wire logic [3:0] i_dir,
  output logic [3:0] o_track_zero_n,
  output logic [31:0] o_pos
);
  logic [3:0] step_q = 4'h0;
  initial o_pos = START;
  // head moves one track per step rise and cannot pass the outer stop
  always @(posedge i_clk)
  begin
    step_q <= i_step;
    for (int d = 0; d < 4; d++)
      if (i_step[d] && !step_q[d])
        if (i_dir[d])
          o_pos[d*8 +: 8] <= o_pos[d*8 +: 8] + 8'h01;
        else if (o_pos[d*8 +: 8] != 8'h00)
          o_pos[d*8 +: 8] <= o_pos[d*8 +: 8] - 8'h01;
  end
  // track zero pin goes high only while the head sits on track 0
  always_comb
    for (int d = 0; d < 4; d++)
      o_track_zero_n[d] = (o_pos[d*8 +: 8] == 8'h00);
endmodule // floppy_drive_model
`default_nettype wire

/* dv/floppy_head_seek_control_properties.sv */
// port-level assertions for the head seek control block
`timescale 1ns/1ps
`default_nettype none
module floppy_head_seek_control_properties
  import fdc_seek_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire fdc_seek_pkg::reg_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] i_track_zero_n,
  input wire logic [3:0] o_step,
  input wire logic [3:0] o_dir,
  input wire logic o_head_load,
  input wire logic o_xfer_go,
  input wire logic o_int
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic recal_q;
  logic [9:0] wide_q;
  // remembers whether drive 0 was last given a recalibrate or a seek
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      recal_q <= 1'b0;
    else if (i_req.wr && i_req.addr == REG_CMD && i_req.wdata[1:0] == 2'h0
             && (i_req.wdata[7:4] == OP_RECAL || i_req.wdata[7:4] == OP_SEEK))
      recal_q <= (i_req.wdata[7:4] == OP_RECAL);
  // counts how long the drive 0 step pulse has been high
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      wide_q <= 10'h000;
    else
      wide_q <= o_step[0] ? wide_q + 10'h001 : 10'h000;

  a_recal_steps_out: assert property (recal_q && o_step[0] |-> !o_dir[0])
    else $error("recalibrate step not outward");
  a_step_width: assert property ($fell(o_step[0]) |-> wide_q == STEP_W_CYC)
    else $error("step pulse width wrong");
  a_dir_held_step: assert property (((o_step & $past(o_step)) != 4'h0)
    |-> ((o_dir ^ $past(o_dir)) & o_step & $past(o_step)) == 4'h0)
    else $error("direction moved during a step");
  a_busy_cmd_only: assert property ($past(i_req.rd) && $past(i_req.addr) == REG_STATUS
    |-> o_rdata[4] == ($past(i_req.wr, 2) && $past(i_req.addr, 2) == REG_CMD))
    else $error("busy outside the command phase");
  a_head_bit_zero: assert property ($past(i_req.rd) && $past(i_req.addr) == REG_RESULT0
    |-> !o_rdata[2])
    else $error("head address bit not zero");
  a_nodma_reads_zero: assert property ($past(i_req.rd) && $past(i_req.addr) == REG_HLT
    |-> !o_rdata[0])
    else $error("no-dma bit not zero");
  a_xfer_needs_load: assert property (o_xfer_go |-> o_head_load)
    else $error("transfer allowed with head unloaded");
  a_poll_int_reset: assert property ($rose(i_rst_n) |-> ##[0:2] o_int)
    else $error("no polling interrupt after reset");
endmodule // floppy_head_seek_control_properties

bind floppy_head_seek_control floppy_head_seek_control_properties i_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(o_rdata), .i_track_zero_n(i_track_zero_n),
  .o_step(o_step), .o_dir(o_dir), .o_head_load(o_head_load), .o_xfer_go(o_xfer_go), .o_int(o_int));
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the head seek control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fdc_seek_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata, r0, r1;
  logic [3:0] tz_n, step, dir;
  logic head_load, xfer_go, intr;
  logic [31:0] pos;
  int bad_count = 0;
  int tests_run = 0;
  int n1, n2;
  // tick length, long enough that step gaps at step code 6 outlast the step pulse
  localparam int UNIT = 64;

  always #4 i_clk = ~i_clk;

  floppy_head_seek_control #(.UNIT_CYCLES(UNIT)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
    .o_rdata(rdata), .i_track_zero_n(tz_n), .o_step(step), .o_dir(dir), .o_head_load(head_load),
    .o_xfer_go(xfer_go), .o_int(intr));
  // drives start on tracks 5, 3, 100 and 0
  floppy_drive_model #(.START(32'h00_64_03_05)) i_drive (.i_clk(i_clk), .i_step(step), .i_dir(dir),
    .o_track_zero_n(tz_n), .o_pos(pos));

  // compares one value and counts it
  task check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // prints the counts and the verdict, then ends the run
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // register bus write, entered just after a rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    req.wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // register bus read, data taken in the following cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    req.rd <= 1'b0;
    @(negedge i_clk);
    d = rdata;
    @(posedge i_clk);
  endtask
  // command write with a status read right behind it
  task cmd(input logic [7:0] c);
    req <= '{REG_CMD, c, 1'b1, 1'b0};
    @(posedge i_clk);
    req <= '{REG_STATUS, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    req.rd <= 1'b0;
    @(negedge i_clk);
    check({7'h00, rdata[4]}, 8'h01);
    @(posedge i_clk);
  endtask
  // command followed by both result reads
  task res(input logic [7:0] c);
    cmd(c);
    rd(REG_RESULT0, r0);
    rd(REG_RESULT1, r1);
  endtask
  // waits for an output level, counting cycles, with a bound
  task wait_on(input int sel, input logic v, output int n);
    logic s;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
      s = (sel == 0) ? intr : (sel == 1) ? head_load : (sel == 2) ? xfer_go : step[0];
      if (n > 50000)
      begin
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        stop_test();
      end
    end
    while (s !== v);
    @(posedge i_clk);
  endtask
  // polling interrupt after reset, then an empty sense
  task t_poll;
    check({7'h00, intr}, 8'h01);
    res(8'h30);
    check(r0 & 8'hf0, 8'hc0);
    check({7'h00, intr}, 8'h00);
    res(8'h30);
    check(r0 & 8'hf0, 8'h80);
  endtask
  // timing registers and the forced dma selection
  task t_regs;
    wr(REG_SPECIFY, 8'hf1);
    wr(REG_HLT, 8'h07);
    rd(REG_HLT, r0);
    check(r0, 8'h06);
    rd(REG_SPECIFY, r0);
    check(r0, 8'hf1);
    rd(8'h3c, r0);
    check(r0, 8'h00);
  endtask
  // four recalibrates in parallel, sensed as each one ends
  task t_recal;
    logic [7:0] exp [4];
    int drv [4];
    exp = '{8'h23, 8'h21, 8'h20, 8'h72};
    drv = '{3, 1, 0, 2};
    for (int d = 0; d < 4; d++)
      cmd(8'h10 | 8'(d));
    for (int i = 0; i < 4; i++)
    begin
      wait_on(0, 1'b1, n1);
      rd(REG_STATUS, r1);
      check({7'h00, r1[drv[i]]}, 8'h01);
      res(8'h30);
      check(r0, exp[i]);
      check(r1, 8'h00);
      rd(REG_STATUS, r1);
      check({7'h00, r1[drv[i]]}, 8'h00);
    end
    check(pos[31:24], 8'h00);
    check(pos[23:16], 8'h15);
  endtask
  // seek to a cylinder, checking direction and later step spacing
  task seek_to(input logic [7:0] t, input logic up);
    wr(REG_TARGET, t);
    cmd(8'h20);
    wait_on(3, 1'b1, n1);
    check({7'h00, dir[0]}, {7'h00, up});
    wait_on(3, 1'b0, n1);
    wait_on(3, 1'b1, n1);
    wait_on(3, 1'b0, n1);
    wait_on(3, 1'b1, n2);
    // step code 6 gives 16 - 6 ticks between rises, one tick of phase slack
    check({7'h00, n1 + n2 >= (16 - 6 - 1) * UNIT && n1 + n2 <= (16 - 6) * UNIT + 4}, 8'h01);
    wait_on(0, 1'b1, n1);
    res(8'h30);
    check(r0, 8'h20);
    check(r1, t);
    check(pos[7:0], t);
  endtask
  // inward then outward seek on drive 0
  task t_seek;
    wr(REG_SPECIFY, 8'h61);
    seek_to(8'h04, 1'b1);
    seek_to(8'h01, 1'b0);
  endtask
  // drive status, then wake clears cylinder and status
  task t_wake;
    res(8'h40);
    check(r0, 8'h20);
    check(r1, 8'h01);
    check({7'h00, intr}, 8'h00);
    cmd(8'h70);
    res(8'h40);
    check(r1, 8'h00);
    res(8'h30);
    check(r0 & 8'hf0, 8'h80);
  endtask
  // head load and unload times at every data rate
  task t_head;
    int tk [4];
    tk = '{UNIT, UNIT * 5 / 3, UNIT * 2, UNIT / 2};
    for (int r = 0; r < 4; r++)
    begin
      wr(REG_RATE, 8'(r));
      cmd(8'h50); // transfer only after the earlier seek and sense
      wait_on(2, 1'b1, n1);
      check({7'h00, head_load}, 8'h01);
      check({7'h00, n1 >= tk[r] * 5 && n1 <= tk[r] * 7 + 4}, 8'h01);
      cmd(8'h60);
      wait_on(0, 1'b1, n1);
      check({7'h00, n1 < 4}, 8'h01);
      wait_on(1, 1'b0, n2);
      check({7'h00, n2 >= tk[r] * 15 && n2 <= tk[r] * 17 + 4}, 8'h01);
      res(8'h30);
      check(r0 & 8'hf0, 8'h00);
    end
  endtask
  // reset, then the scenarios in order
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_poll();
    t_regs();
    t_recal();
    t_seek();
    t_wake();
    t_head();
    stop_test();
  end
endmodule // tb
`default_nettype wire
